// ---- rtl/timer_counters.sv ----
`timescale 1ns/1ps
module timer_counters
    import timer_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst,
    input  wire logic     ce,
    input  wire sfr_req_t sfr,
    output logic [7:0]    sfr_rdata,
    input  wire pin_in_t  pins,
    input  wire logic     t0_irq_ack,
    input  wire logic     t1_irq_ack,
    output logic          t0_overflow_flag,
    output logic          t1_overflow_flag,
    output logic          t2_overflow_flag,
    output logic          t2_external_flag,
    output logic          rx_baud_tick,
    output logic          tx_baud_tick
);

    // ==================================================================
    // one timer/counter step for modes 0..3; in mode 3 only the low byte, the split high byte is handled by the caller
    function automatic count_step_t step(input logic [1:0] mode, input logic [7:0] hi,
                                         input logic [7:0] lo, input logic tick);
        count_step_t r;
        r.high = hi;
        r.low  = lo;
        r.ovf  = 1'b0;
        if (tick) begin
            unique case (mode)
                MODE_13BIT: begin
                    r.low[4:0] = lo[4:0] + 5'h01;
                    if (lo[4:0] == 5'h1f) begin
                        r.high = hi + 8'h01;
                        r.ovf  = (hi == 8'hff);
                    end
                end
                MODE_16BIT: begin
                    {r.high, r.low} = {hi, lo} + 16'h0001;
                    r.ovf = ({hi, lo} == 16'hffff);
                end
                MODE_RELOAD: begin
                    r.low = (lo == 8'hff) ? hi : lo + 8'h01;
                    r.ovf = (lo == 8'hff);
                end
                MODE_SPLIT: begin
                    r.low = lo + 8'h01;
                    r.ovf = (lo == 8'hff);
                end
            endcase
        end
        return r;
    endfunction

    // ==================================================================
    // pin synchronisers
    logic [PIN_COUNT-1:0] pin_vec;
    logic [PIN_COUNT-1:0] pin_lvl;
    logic [PIN_COUNT-1:0] pin_fall;

    assign pin_vec = pins;

    generate
        for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
            pin_edge_sync #(
                .STAGES (2)
            ) u_sync (
                .clk   (clk),
                .rst   (rst),
                .ce    (ce),
                .pin   (pin_vec[i]),
                .level (pin_lvl[i]),
                .fall  (pin_fall[i])
            );
        end
    endgenerate

    // bit order follows pin_in_t, first member in the top bit
    logic t0_cnt_fall;
    logic t1_cnt_fall;
    logic t2_cnt_fall;
    logic t2_trig_fall;
    logic irq0_lvl;
    logic irq1_lvl;

    assign t0_cnt_fall  = pin_fall[5];
    assign t1_cnt_fall  = pin_fall[4];
    assign t2_cnt_fall  = pin_fall[3];
    assign t2_trig_fall = pin_fall[2];
    assign irq0_lvl     = pin_lvl[1];
    assign irq1_lvl     = pin_lvl[0];

    // ==================================================================
    // register state
    logic [7:0] t0_low_r;
    logic [7:0] t0_high_r;
    logic [7:0] t1_low_r;
    logic [7:0] t1_high_r;
    logic [7:0] t2_low_r;
    logic [7:0] t2_high_r;
    logic [7:0] rcap_low_r;
    logic [7:0] rcap_high_r;
    logic [7:0] mode_r;
    logic       t0_run_r;
    logic       t1_run_r;
    logic       t0_flag_r;
    logic       t1_flag_r;
    logic [3:0] irq_bits_r;
    logic [5:0] t2_ctl_r;
    logic       t2_flag_r;
    logic       t2_ext_r;
    logic [7:0] rdata_r;
    logic       rx_tick_r;
    logic       tx_tick_r;

    logic wr_timer01_control;
    logic wr_timer01_mode;
    logic wr_t0l;
    logic wr_t0h;
    logic wr_t1l;
    logic wr_t1h;
    logic wr_timer2_control;
    logic wr_rcl;
    logic wr_rch;
    logic wr_t2l;
    logic wr_t2h;

    assign wr_timer01_control  = sfr.wr && sfr.addr == ADDR_TIMER01_CONTROL;
    assign wr_timer01_mode  = sfr.wr && sfr.addr == ADDR_TIMER01_MODE;
    assign wr_t0l   = sfr.wr && sfr.addr == ADDR_T0_COUNT_LOW;
    assign wr_t0h   = sfr.wr && sfr.addr == ADDR_T0_COUNT_HIGH;
    assign wr_t1l   = sfr.wr && sfr.addr == ADDR_T1_COUNT_LOW;
    assign wr_t1h   = sfr.wr && sfr.addr == ADDR_T1_COUNT_HIGH;
    assign wr_timer2_control = sfr.wr && sfr.addr == ADDR_TIMER2_CONTROL;
    assign wr_rcl   = sfr.wr && sfr.addr == ADDR_T2_RELOAD_LOW;
    assign wr_rch   = sfr.wr && sfr.addr == ADDR_T2_RELOAD_HIGH;
    assign wr_t2l   = sfr.wr && sfr.addr == ADDR_T2_COUNT_LOW;
    assign wr_t2h   = sfr.wr && sfr.addr == ADDR_T2_COUNT_HIGH;

    // ==================================================================
    // timers 0 and 1 count enables
    logic [1:0] t0_mode;
    logic [1:0] t1_mode;
    logic       t0_split;
    logic       t0_tick;
    logic       t1_tick;
    logic       th0_tick;

    assign t0_mode  = mode_r[T0_MODE_LSB +: 2];
    assign t1_mode  = mode_r[T1_MODE_LSB +: 2];
    assign t0_split = (t0_mode == MODE_SPLIT);

    // no prescaler: timer function ticks every enabled core clock
    assign t0_tick = t0_run_r && (!mode_r[T0_GATE_BIT] || irq0_lvl)
                     && (mode_r[T0_CS_BIT] ? t0_cnt_fall : 1'b1);
    // with timer 0 split, its high byte owns the run bit; timer 1 runs unless in mode 3
    assign t1_tick = (t0_split || t1_run_r) && (!mode_r[T1_GATE_BIT] || irq1_lvl)
                     && (mode_r[T1_CS_BIT] ? t1_cnt_fall : 1'b1)
                     && (t1_mode != MODE_SPLIT);
    // split high byte counts core clocks under timer 1 run bit only
    assign th0_tick = t0_split && t1_run_r;

    count_step_t t0_nxt;
    count_step_t t1_nxt;
    logic [7:0]  th0_split_nxt;
    logic        th0_split_ovf;

    assign t0_nxt        = step(t0_mode, t0_high_r, t0_low_r, t0_tick);
    assign t1_nxt        = step(t1_mode, t1_high_r, t1_low_r, t1_tick);
    assign th0_split_nxt = t0_high_r + 8'h01;
    assign th0_split_ovf = th0_tick && (t0_high_r == 8'hff);

    // software writes win over the count step for the byte written
    always_ff @(posedge clk) begin
        if (rst) begin
            t0_low_r  <= SFR_RESET;
            t0_high_r <= SFR_RESET;
        end else if (ce) begin
            t0_low_r <= wr_t0l ? sfr.wdata : t0_nxt.low;
            if (wr_t0h) begin
                t0_high_r <= sfr.wdata;
            end else if (t0_split) begin
                if (th0_tick) begin
                    t0_high_r <= th0_split_nxt;
                end
            end else begin
                t0_high_r <= t0_nxt.high;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            t1_low_r  <= SFR_RESET;
            t1_high_r <= SFR_RESET;
        end else if (ce) begin
            t1_low_r  <= wr_t1l ? sfr.wdata : t1_nxt.low;
            t1_high_r <= wr_t1h ? sfr.wdata : t1_nxt.high;
        end
    end

    // ==================================================================
    // timer 0/1 control, mode and flags
    logic t0_flag_set;
    logic t1_flag_set;

    assign t0_flag_set = t0_nxt.ovf;
    // in split mode timer 1 loses its flag to the high byte of timer 0
    assign t1_flag_set = t0_split ? th0_split_ovf : t1_nxt.ovf;

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r     <= SFR_RESET;
            t0_run_r   <= 1'b0;
            t1_run_r   <= 1'b0;
            irq_bits_r <= 4'h0;
        end else if (ce) begin
            if (wr_timer01_mode) begin
                mode_r <= sfr.wdata;
            end
            if (wr_timer01_control) begin
                // run bits only gate counting, count registers untouched
                t0_run_r   <= sfr.wdata[T0_RUN_BIT];
                t1_run_r   <= sfr.wdata[T1_RUN_BIT];
                irq_bits_r <= sfr.wdata[3:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            t0_flag_r <= 1'b0;
            t1_flag_r <= 1'b0;
        end else if (ce) begin
            if (t0_flag_set) begin
                t0_flag_r <= 1'b1;
            end else if (wr_timer01_control) begin
                t0_flag_r <= sfr.wdata[T0_FLAG_BIT];
            end else if (t0_irq_ack) begin
                t0_flag_r <= 1'b0;
            end
            if (t1_flag_set) begin
                t1_flag_r <= 1'b1;
            end else if (wr_timer01_control) begin
                t1_flag_r <= sfr.wdata[T1_FLAG_BIT];
            end else if (t1_irq_ack) begin
                t1_flag_r <= 1'b0;
            end
        end
    end

    // ==================================================================
    // timer 2
    logic        rx_sel;
    logic        tx_sel;
    logic        baud_mode;
    logic        t2_tick;
    logic        t2_ovf;
    logic        t2_trig;
    logic        t2_capture;
    logic        t2_reload;
    logic [15:0] t2_count;
    logic [15:0] t2_next;

    assign rx_sel    = t2_ctl_r[T2_RXBAUD_BIT];
    assign tx_sel    = t2_ctl_r[T2_TXBAUD_BIT];
    assign baud_mode = rx_sel || tx_sel;
    assign t2_count  = {t2_high_r, t2_low_r};

    assign t2_tick = t2_ctl_r[T2_RUN_BIT]
                     && (t2_ctl_r[T2_CS_BIT] ? t2_cnt_fall : 1'b1);
    assign t2_ovf  = t2_tick && (t2_count == 16'hffff);
    // trigger ignored while timer 2 clocks the serial port
    assign t2_trig = t2_ctl_r[T2_TRIGEN_BIT] && t2_trig_fall && !baud_mode;
    assign t2_capture = t2_trig && t2_ctl_r[T2_CAPSEL_BIT];
    assign t2_reload  = (t2_ovf && (baud_mode || !t2_ctl_r[T2_CAPSEL_BIT]))
                        || (t2_trig && !t2_ctl_r[T2_CAPSEL_BIT]);

    always_comb begin
        if (t2_reload) begin
            t2_next = {rcap_high_r, rcap_low_r};
        end else if (t2_tick) begin
            t2_next = t2_count + 16'h0001;
        end else begin
            t2_next = t2_count;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            t2_low_r  <= SFR_RESET;
            t2_high_r <= SFR_RESET;
        end else if (ce) begin
            t2_low_r  <= wr_t2l ? sfr.wdata : t2_next[7:0];
            t2_high_r <= wr_t2h ? sfr.wdata : t2_next[15:8];
        end
    end

    // a capture edge beats a software write in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            rcap_low_r  <= SFR_RESET;
            rcap_high_r <= SFR_RESET;
        end else if (ce) begin
            if (t2_capture) begin
                rcap_low_r  <= t2_low_r;
                rcap_high_r <= t2_high_r;
            end else begin
                if (wr_rcl) begin
                    rcap_low_r <= sfr.wdata;
                end
                if (wr_rch) begin
                    rcap_high_r <= sfr.wdata;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            t2_ctl_r  <= 6'h00;
            t2_flag_r <= 1'b0;
            t2_ext_r  <= 1'b0;
        end else if (ce) begin
            if (wr_timer2_control) begin
                t2_ctl_r <= sfr.wdata[5:0];
            end
            if (t2_ovf && !baud_mode) begin
                t2_flag_r <= 1'b1;
            end else if (wr_timer2_control) begin
                t2_flag_r <= sfr.wdata[T2_FLAG_BIT];
            end
            if (t2_trig) begin
                t2_ext_r <= 1'b1;
            end else if (wr_timer2_control) begin
                t2_ext_r <= sfr.wdata[T2_EXT_BIT];
            end
        end
    end

    // ==================================================================
    // baud ticks; timer 1 still ticks here in split mode without its flag
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_tick_r <= 1'b0;
            tx_tick_r <= 1'b0;
        end else if (ce) begin
            rx_tick_r <= rx_sel ? t2_ovf : t1_nxt.ovf;
            tx_tick_r <= tx_sel ? t2_ovf : t1_nxt.ovf;
        end
    end

    // ==================================================================
    // read data, one cycle after the address
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= SFR_RESET;
        end else if (ce) begin
            unique case (sfr.addr)
                ADDR_TIMER01_CONTROL: rdata_r <= {t1_flag_r, t1_run_r, t0_flag_r, t0_run_r,
                                                  irq_bits_r};
                ADDR_TIMER01_MODE:    rdata_r <= mode_r;
                ADDR_T0_COUNT_LOW:    rdata_r <= t0_low_r;
                ADDR_T0_COUNT_HIGH:   rdata_r <= t0_high_r;
                ADDR_T1_COUNT_LOW:    rdata_r <= t1_low_r;
                ADDR_T1_COUNT_HIGH:   rdata_r <= t1_high_r;
                ADDR_TIMER2_CONTROL:  rdata_r <= {t2_flag_r, t2_ext_r, t2_ctl_r};
                ADDR_T2_RELOAD_LOW:   rdata_r <= rcap_low_r;
                ADDR_T2_RELOAD_HIGH:  rdata_r <= rcap_high_r;
                ADDR_T2_COUNT_LOW:    rdata_r <= t2_low_r;
                ADDR_T2_COUNT_HIGH:   rdata_r <= t2_high_r;
                default:              rdata_r <= SFR_RESET;
            endcase
        end
    end

    assign sfr_rdata        = rdata_r;
    assign t0_overflow_flag = t0_flag_r;
    assign t1_overflow_flag = t1_flag_r;
    assign t2_overflow_flag = t2_flag_r;
    assign t2_external_flag = t2_ext_r;
    assign rx_baud_tick     = rx_tick_r;
    assign tx_baud_tick     = tx_tick_r;

endmodule

// ---- shared/timer_pkg.sv ----
package timer_pkg;

    // ==================================================================
    // special function register addresses
    localparam logic [7:0] ADDR_TIMER01_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_TIMER01_MODE    = 8'h89;
    localparam logic [7:0] ADDR_T0_COUNT_LOW    = 8'h8a;
    localparam logic [7:0] ADDR_T1_COUNT_LOW    = 8'h8b;
    localparam logic [7:0] ADDR_T0_COUNT_HIGH   = 8'h8c;
    localparam logic [7:0] ADDR_T1_COUNT_HIGH   = 8'h8d;
    localparam logic [7:0] ADDR_TIMER2_CONTROL  = 8'hc8;
    localparam logic [7:0] ADDR_T2_RELOAD_LOW   = 8'hca;
    localparam logic [7:0] ADDR_T2_RELOAD_HIGH  = 8'hcb;
    localparam logic [7:0] ADDR_T2_COUNT_LOW    = 8'hcc;
    localparam logic [7:0] ADDR_T2_COUNT_HIGH   = 8'hcd;

    // ==================================================================
    // timer01_control bit positions
    localparam int T1_FLAG_BIT = 7;
    localparam int T1_RUN_BIT  = 6;
    localparam int T0_FLAG_BIT = 5;
    localparam int T0_RUN_BIT  = 4;

    // timer01_mode field positions (timer 1 in upper nibble)
    localparam int T1_GATE_BIT = 7;
    localparam int T1_CS_BIT   = 6;
    localparam int T1_MODE_LSB = 4;
    localparam int T0_GATE_BIT = 3;
    localparam int T0_CS_BIT   = 2;
    localparam int T0_MODE_LSB = 0;

    // timer2_control bit positions
    localparam int T2_FLAG_BIT    = 7;
    localparam int T2_EXT_BIT     = 6;
    localparam int T2_RXBAUD_BIT  = 5;
    localparam int T2_TXBAUD_BIT  = 4;
    localparam int T2_TRIGEN_BIT  = 3;
    localparam int T2_RUN_BIT     = 2;
    localparam int T2_CS_BIT      = 1;
    localparam int T2_CAPSEL_BIT  = 0;

    // ==================================================================
    // reset values and modes
    localparam logic [7:0] SFR_RESET = 8'h00;

    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    localparam int PIN_COUNT = 6;

    // ==================================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic t0_count_pin;
        logic t1_count_pin;
        logic t2_count_pin;
        logic t2_trigger_pin;
        logic ext_irq0_pin;
        logic ext_irq1_pin;
    } pin_in_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
        logic       ovf;
    } count_step_t;

endpackage

// ---- rtl/pin_edge_sync.sv ----
`timescale 1ns/1ps
module pin_edge_sync
    import timer_pkg::*;
#(
    parameter int STAGES = 2
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic pin,
    output logic      level,
    output logic      fall
);

    // ==================================================================
    // synchroniser and falling edge detector
    logic [STAGES-1:0] sync_r;
    logic              prev_r;

    // refused at elaboration: one stage would let a metastable sample reach the logic
    generate
        if (STAGES < 2) begin : g_bad_stages
            $error("pin_edge_sync needs at least two stages");
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            sync_r <= '0;
            prev_r <= 1'b0;
        end else if (ce) begin
            sync_r <= {sync_r[STAGES-2:0], pin};
            prev_r <= sync_r[STAGES-1];
        end
    end

    assign level = sync_r[STAGES-1];
    // high sample followed by low sample
    assign fall  = prev_r & ~sync_r[STAGES-1];

endmodule

// ---- testbench/timer_counters_monitor.sv ----
`timescale 1ns/1ps
module timer_counters_monitor
    import timer_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ce,
    input wire sfr_req_t   sfr,
    input wire logic [7:0] sfr_rdata,
    input wire logic       t0_irq_ack,
    input wire logic       t0_overflow_flag,
    input wire logic       t1_overflow_flag,
    input wire logic       t2_overflow_flag,
    input wire logic       t2_external_flag,
    input wire logic       rx_baud_tick,
    input wire logic       tx_baud_tick
);
    // ==================================================================
    // shadow of the software-only timer 2 control bits
    logic [1:0] baud_r;
    logic       trig_en_r;
    logic       c8_wr;
    logic       c88_wr;
    assign c8_wr  = ce && sfr.wr && sfr.addr == ADDR_TIMER2_CONTROL;
    assign c88_wr = ce && sfr.wr && sfr.addr == ADDR_TIMER01_CONTROL;
    always_ff @(posedge clk) begin
        if (rst) begin
            baud_r    <= 2'h0;
            trig_en_r <= 1'b0;
        end else if (c8_wr) begin
            baud_r    <= sfr.wdata[T2_RXBAUD_BIT:T2_TXBAUD_BIT];
            trig_en_r <= sfr.wdata[T2_TRIGEN_BIT];
        end
    end
    // ==================================================================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence mode_wr;
        ce && sfr.wr && sfr.addr == ADDR_TIMER01_MODE;
    endsequence
    sequence mode_rd;
        ce && !sfr.wr && sfr.addr == ADDR_TIMER01_MODE;
    endsequence
    a_mode_read_back: assert property (mode_wr ##1 mode_rd |=> sfr_rdata == $past(sfr.wdata, 2))
        else $error("mode register read back wrong");
    a_reset_clears_all: assert property (disable iff (1'b0) rst && ce |=> sfr_rdata == 8'h00
        && !(t0_overflow_flag || t1_overflow_flag || t2_overflow_flag || t2_external_flag)
        && !rx_baud_tick && !tx_baud_tick)
        else $error("outputs not cleared by reset");
    a_t2_flag_nobaud: assert property ($rose(t2_overflow_flag) && !$past(c8_wr)
        |-> $past(baud_r) == 2'h0)
        else $error("timer 2 flag set while baud source");
    a_ext_needs_en: assert property ($rose(t2_external_flag) && !$past(c8_wr)
        |-> $past(trig_en_r) && $past(baud_r) == 2'h0)
        else $error("external flag set without trigger enable");
    a_t2_flag_holds: assert property (t2_overflow_flag
        && !(c8_wr && !sfr.wdata[T2_FLAG_BIT]) |=> t2_overflow_flag)
        else $error("timer 2 flag dropped without clear");
    a_ext_flag_holds: assert property (t2_external_flag
        && !(c8_wr && !sfr.wdata[T2_EXT_BIT]) |=> t2_external_flag)
        else $error("external flag dropped without clear");
    a_t0_flag_holds: assert property (t0_overflow_flag && !t0_irq_ack
        && !(c88_wr && !sfr.wdata[T0_FLAG_BIT]) |=> t0_overflow_flag)
        else $error("timer 0 flag dropped without clear");
    a_baud_both_same: assert property (baud_r == 2'h3 && $past(baud_r) == 2'h3
        && $past(baud_r, 2) == 2'h3 |-> rx_baud_tick == tx_baud_tick)
        else $error("receive and transmit ticks differ");
endmodule
bind timer_counters timer_counters_monitor u_mon (.clk(clk), .rst(rst), .ce(ce), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .t0_irq_ack(t0_irq_ack), .t0_overflow_flag(t0_overflow_flag),
    .t1_overflow_flag(t1_overflow_flag), .t2_overflow_flag(t2_overflow_flag),
    .t2_external_flag(t2_external_flag), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick));

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
    import timer_pkg::*;
`define CHK(g, x) \
    begin \
        n_tests++; \
        if ((g) !== (x)) begin \
            errors++; \
            $display("MISMATCH t=%0t got %h exp %h", $time, g, x); \
        end \
    end
    logic        clk, rst, ce, ack, f;
    sfr_req_t    sfr;
    pin_in_t     pins;
    logic [7:0]  rdata, lo, hi, ctl;
    logic [3:0]  fl;
    logic [1:0]  tk, m;
    logic [15:0] cv, rv, got, ex;
    count_step_t e;
    int          errors, n_tests, k, n, n_rx, n_tx;
    logic [7:0]  regs [13] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8, 8'hca,
                               8'hcb, 8'hcc, 8'hcd, 8'h00, 8'hc9};
    logic [7:0]  trig_ctl [4] = '{8'h01, 8'h09, 8'h08, 8'h38};
    timer_counters u_timer_counters (.clk(clk), .rst(rst), .ce(ce), .sfr(sfr),
        .sfr_rdata(rdata), .pins(pins), .t0_irq_ack(ack), .t1_irq_ack(ack),
        .t0_overflow_flag(fl[0]), .t1_overflow_flag(fl[1]), .t2_overflow_flag(fl[2]),
        .t2_external_flag(fl[3]), .rx_baud_tick(tk[1]), .tx_baud_tick(tk[0]));
    // ==================================================================
    // bus tasks and reference model
    task automatic tick(input int c);
        sfr.wr <= 1'b0;
        repeat (c) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr <= '{a, 1'b1, d};
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr <= '{a, 1'b0, 8'h00};
        @(posedge clk);
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 8'h1, d[15:8]);
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] d);
        rd(a, d[7:0]);
        rd(a + 8'h1, d[15:8]);
    endtask
    function automatic count_step_t step(input logic [1:0] md, input count_step_t s,
                                         input int c);
        logic cy;
        for (int j = 0; j < c; j++) begin
            if (md[1]) begin
                s.low = s.low + 8'h1;
                s.ovf |= s.low == 8'h00;
                if (md == MODE_RELOAD && s.low == 8'h00)
                    s.low = s.high;
            end else begin
                cy = md == MODE_16BIT ? s.low == 8'hff : s.low[4:0] == 5'h1f;
                if (md == MODE_16BIT)
                    s.low = s.low + 8'h1;
                else
                    s.low[4:0] = s.low[4:0] + 5'h1;
                if (cy) begin
                    s.ovf |= s.high == 8'hff;
                    s.high = s.high + 8'h1;
                end
            end
        end
        return s;
    endfunction
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ==================================================================
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(negedge clk) begin
        n_rx += tk[1];
        n_tx += tk[0];
    end
    initial begin
        #(20 * 20000);
        errors++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        ack = 1'b0;
        sfr = '0;
        pins = '1;
        k = $urandom(32'h5cb7);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) begin
            rd(regs[i], lo);
            `CHK(lo, 8'h00)
        end
        foreach (regs[i]) begin
            if (regs[i] inside {ADDR_TIMER01_CONTROL, ADDR_TIMER2_CONTROL})
                continue;
            hi = 8'($urandom);
            wr(regs[i], hi);
            rd(regs[i], lo);
            `CHK(lo, i < 11 ? hi : 8'h00)
        end
        // timer 0 in each mode, last pass gated by the interrupt pin
        for (int i = 0; i < 5; i++) begin
            m = i == 4 ? MODE_16BIT : 2'(i);
            k = $urandom_range(40, 10);
            f = 1'($urandom);
            pins.ext_irq0_pin <= f;
            e = '{i[1] ? 8'($urandom) : 8'hff, 8'he0 | 8'($urandom_range(31)), 1'b0};
            wr(ADDR_TIMER01_MODE, {4'h0, i == 4, 1'b0, m});
            wr(ADDR_T0_COUNT_LOW, e.low);
            wr(ADDR_T0_COUNT_HIGH, e.high);
            wr(ADDR_TIMER01_CONTROL, 8'h10);
            tick(k - 1);
            e = step(m, e, i == 4 && !f ? 0 : k);
            // writing back the expected flag keeps an earlier overflow visible
            wr(ADDR_TIMER01_CONTROL, {2'h0, e.ovf, 5'h0});
            rd(ADDR_T0_COUNT_LOW, lo);
            rd(ADDR_T0_COUNT_HIGH, hi);
            `CHK({hi, lo, fl[0]}, e)
            ack <= 1'b1;
            tick(1);
            ack <= 1'b0;
            tick(1);
            `CHK(fl[0], 1'b0)
        end
        // split timer 0: timer 1 runs by its mode alone, high byte takes its run bit and flag
        wr(ADDR_T1_COUNT_LOW, 8'hfa);
        wr(ADDR_T1_COUNT_HIGH, 8'hf0);
        wr(ADDR_T0_COUNT_HIGH, 8'hf8);
        n_rx = 0;
        n_tx = 0;
        wr(ADDR_TIMER01_MODE, 8'h23);
        tick(10);
        wr(ADDR_TIMER01_MODE, 8'h33);
        rd(ADDR_T0_COUNT_HIGH, hi);
        `CHK({hi, fl[1]}, {8'hf8, 1'b0})
        wr(ADDR_TIMER01_CONTROL, 8'h40);
        // a low clock enable freezes the high byte for three edges
        ce <= 1'b0;
        tick(3);
        ce <= 1'b1;
        tick(8);
        rd(ADDR_T1_COUNT_LOW, lo);
        `CHK({lo, fl[1], n_rx[1:0], n_tx[1:0]}, {8'hf5, 1'b1, 2'h1, 2'h1})
        wr(ADDR_TIMER01_CONTROL, 8'h00);
        rd(ADDR_T0_COUNT_HIGH, hi);
        `CHK(hi, 8'h03)
        // timer 2 overflow with every baud select, then counting pin edges
        for (int i = 0; i < 5; i++) begin
            k = $urandom_range(30, 5);
            cv = 16'hfff0 | 16'($urandom_range(15));
            rv = 16'($urandom_range(32767));
            ctl = {2'h0, i < 4 ? 2'(i) : 2'h0, 1'b0, 1'b1, i == 4, 1'($urandom)};
            wr16(ADDR_T2_RELOAD_LOW, rv);
            wr16(ADDR_T2_COUNT_LOW, cv);
            n_rx = 0;
            n_tx = 0;
            wr(ADDR_TIMER2_CONTROL, ctl);
            if (i == 4) begin
                repeat (k) begin
                    pins.t2_count_pin <= 1'b0;
                    tick(2);
                    pins.t2_count_pin <= 1'b1;
                    tick(2);
                end
                tick(4);
            end else
                tick(k - 1);
            n = 32'h10000 - cv;
            ex = k < n ? cv + 16'(k) : (ctl[5:4] == 2'h0 && ctl[0] ? 16'h0 : rv) + 16'(k - n);
            f = k >= n && ctl[5:4] == 2'h0;
            wr(ADDR_TIMER2_CONTROL, {f, 6'h0, ctl[0]});
            rd16(ADDR_T2_COUNT_LOW, got);
            `CHK(got, ex)
            `CHK({fl[2], n_rx[0], n_tx[0]}, {f, k >= n && ctl[5], k >= n && ctl[4]})
        end
        // trigger pin: ignored, capture, reload, ignored in baud mode
        for (int i = 0; i < 4; i++) begin
            cv = 16'($urandom);
            rv = ~cv;
            wr16(ADDR_T2_RELOAD_LOW, rv);
            wr16(ADDR_T2_COUNT_LOW, cv);
            wr(ADDR_TIMER2_CONTROL, trig_ctl[i]);
            pins.t2_trigger_pin <= 1'b0;
            tick(6);
            pins.t2_trigger_pin <= 1'b1;
            tick(4);
            rd16(ADDR_T2_RELOAD_LOW, got);
            rd16(ADDR_T2_COUNT_LOW, ex);
            `CHK({got, ex, fl[3]}, {i == 1 ? cv : rv, i == 2 ? rv : cv, i == 1 || i == 2})
        end
        tally_and_finish();
    end
endmodule
